/* dv/scan_ctrl_model.sv */
`timescale 1ns/1ps

module scan_ctrl_model (
  input wire logic sys_clk,
  output tap_pkg::tap_pins_t pins,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  // TCK idles high so the first step starts with a falling edge
  initial begin
    pins = '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
  end

  // One TCK cycle of 31 sys_clk; the device answer is read late in the
  // low phase, well after its synchroniser delay has passed
  task automatic step(input logic tms, input logic tdi,
      output logic tdo_seen, output logic oe_n_seen);
    @(posedge sys_clk);
    pins.tck <= 1'b0;
    pins.tms <= tms;
    pins.tdi <= tdi;
    repeat (15) @(posedge sys_clk);
    tdo_seen = tdo;
    oe_n_seen = tdo_oe_n;
    pins.tck <= 1'b1;
    repeat (15) @(posedge sys_clk);
  endtask
endmodule

/* dv/tap_scan_sequence_port_bench.sv */
`timescale 1ns/1ps

module tap_scan_sequence_port_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic dr_word_ready = 1'b0;
  tap_pkg::tap_pins_t pins;
  logic tdo, tdo_oe_n, bypass_sel, dr_push_ready, dr_word_valid;
  tap_pkg::tap_state_t tap_state;
  logic [7:0] ir_out, dr_out, dr_word;
  int n_fail = 0;
  int n_tests = 0;

  always #2 sys_clk = ~sys_clk;

  tap_scan_sequence_port dut (.sys_clk(sys_clk), .reset(reset),
    .pins(pins), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tap_state(tap_state),
    .ir_out(ir_out), .bypass_sel(bypass_sel), .dr_out(dr_out),
    .dr_push_ready(dr_push_ready), .dr_word_valid(dr_word_valid),
    .dr_word_ready(dr_word_ready), .dr_word(dr_word));

  scan_ctrl_model ctrl (.sys_clk(sys_clk), .pins(pins), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));

  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // From Select-DR: scan n bits LSB first, finish back in Select-DR
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
      input logic [7:0] dexp);
    logic o, e;
    logic [7:0] got;
    got = 8'h00;
    if (ir) ctrl.step(1'b1, 1'b0, o, e);
    ctrl.step(1'b0, 1'b0, o, e);
    ctrl.step(1'b0, 1'b0, o, e);
    for (int i = 0; i < n; i++) begin
      ctrl.step(i == n - 1, din[i], o, e);
      got[i] = o;
      check("oe_n in shift", {7'h00, e}, 8'h00);
    end
    ctrl.step(1'b1, 1'b0, o, e);
    check("oe_n in exit1", {7'h00, e}, 8'h01);
    ctrl.step(1'b1, 1'b0, o, e);
    check("scan out", got, dexp);
    check("state", {4'h0, tap_state}, {4'h0, tap_pkg::SEL_DR});
  endtask

  task automatic test_ir_bypass();
    logic o, e;
    ctrl.step(1'b0, 1'b0, o, e);
    ctrl.step(1'b1, 1'b0, o, e);
    scan(1'b1, 8, 8'hff, tap_pkg::IR_CAPTURE);
    check("ir_out", ir_out, tap_pkg::IR_BYPASS);
    check("bypass_sel", {7'h00, bypass_sel}, 8'h01);
    $display("test ir_bypass done");
  endtask

  task automatic test_bypass_dr();
    logic o, e;
    scan(1'b0, 3, 8'h05, 8'h02);
    ctrl.step(1'b1, 1'b0, o, e);
    ctrl.step(1'b1, 1'b0, o, e);
    check("state", {4'h0, tap_state}, {4'h0, tap_pkg::TLR});
    $display("test bypass_dr done");
  endtask

  // Far side stalls while 17 words arrive; the last must be dropped
  task automatic test_fifo();
    logic o, e;
    logic [7:0] prev;
    ctrl.step(1'b0, 1'b0, o, e);
    ctrl.step(1'b1, 1'b0, o, e);
    scan(1'b1, 8, 8'h01, tap_pkg::IR_CAPTURE);
    check("ir_out", ir_out, 8'h01);
    check("bypass_sel", {7'h00, bypass_sel}, 8'h00);
    prev = tap_pkg::TDR_RESET;
    for (int k = 0; k < 17; k++) begin
      scan(1'b0, 8, 8'h10 + k[7:0], prev);
      prev = 8'h10 + k[7:0];
      check("dr_out", dr_out, prev);
    end
    check("push_ready", {7'h00, dr_push_ready}, 8'h00);
    for (int k = 0; k < 16; k++) begin
      check("valid", {7'h00, dr_word_valid}, 8'h01);
      check("dr_word", dr_word, 8'h10 + k[7:0]);
      @(posedge sys_clk) dr_word_ready <= 1'b1;
      @(posedge sys_clk) dr_word_ready <= 1'b0;
      @(posedge sys_clk);
    end
    check("valid empty", {7'h00, dr_word_valid}, 8'h00);
    $display("test fifo done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    test_ir_bypass();
    test_bypass_dr();
    test_fifo();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule

/* logic/tap_pkg.sv */
package tap_pkg;
  localparam int IR_W = 8;
  localparam int DR_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_BYPASS = 8'hff;
  localparam logic [7:0] TDR_RESET = 8'h00;
  localparam logic BYP_CAPTURE = 1'h0;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;
endpackage

/* logic/tap_scan_sequence_port.sv */
`timescale 1ns/1ps

module scan_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;

  assign empty = wr_ptr_r == rd_ptr_r;
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_ptr_r <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

module tap_scan_sequence_port (
  input wire logic sys_clk,
  input wire logic reset,
  input tap_pkg::tap_pins_t pins,
  output logic tdo,
  output logic tdo_oe_n,
  output tap_pkg::tap_state_t tap_state,
  output logic [tap_pkg::IR_W-1:0] ir_out,
  output logic bypass_sel,
  output logic [tap_pkg::DR_W-1:0] dr_out,
  output logic dr_push_ready,
  output logic dr_word_valid,
  input wire logic dr_word_ready,
  output logic [tap_pkg::DR_W-1:0] dr_word
);
  tap_pkg::tap_pins_t sync1_r;
  tap_pkg::tap_pins_t sync2_r;
  logic tck_d_r;
  logic rise;
  logic fall;
  tap_pkg::tap_state_t state_r;
  tap_pkg::tap_state_t state_nxt;
  logic [tap_pkg::IR_W-1:0] ir_sh_r;
  logic [tap_pkg::IR_W-1:0] ir_r;
  logic byp_r;
  logic [tap_pkg::DR_W-1:0] tdr_sh_r;
  logic [tap_pkg::DR_W-1:0] tdr_r;
  logic tdo_r;
  logic oe_n_r;
  logic push;
  logic shifting;
  logic tms;
  localparam int ARM_W = 3;
  logic [ARM_W-1:0] arm_r;

  // TCK is just another async pin; edges are found after synchronising.
  // Edges are ignored until the detector holds the pin's real level, so
  // an idle-high TCK gives no false rise just after reset.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      tck_d_r <= 1'b0;
      arm_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r.tck;
      arm_r <= {arm_r[ARM_W-2:0], 1'b1};
    end
  end

  assign rise = arm_r[ARM_W-1] && sync2_r.tck && !tck_d_r;
  assign fall = arm_r[ARM_W-1] && !sync2_r.tck && tck_d_r;
  assign tms = sync2_r.tms;
  assign shifting = (state_r == tap_pkg::SH_IR) ||
                    (state_r == tap_pkg::SH_DR);

  always_comb begin
    state_nxt = tap_pkg::TLR;
    case (state_r)
      tap_pkg::TLR: state_nxt = tms ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: state_nxt = tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: state_nxt = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR: state_nxt = tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: state_nxt = tms ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: state_nxt = tms ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: state_nxt = tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: state_nxt = tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: state_nxt = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR: state_nxt = tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: state_nxt = tms ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: state_nxt = tms ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: state_nxt = tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: state_nxt = tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default: state_nxt = tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= tap_pkg::TLR;
    end else if (rise) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ir_sh_r <= tap_pkg::IR_CAPTURE;
    end else if (rise && state_r == tap_pkg::CAP_IR) begin
      ir_sh_r <= tap_pkg::IR_CAPTURE;
    end else if (rise && state_r == tap_pkg::SH_IR) begin
      ir_sh_r <= {sync2_r.tdi, ir_sh_r[tap_pkg::IR_W-1:1]};
    end
  end

  // Reset state falls back to bypass so a stuck scan chain stays short
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ir_r <= tap_pkg::IR_BYPASS;
    end else if (state_r == tap_pkg::TLR) begin
      ir_r <= tap_pkg::IR_BYPASS;
    end else if (fall && state_r == tap_pkg::UPD_IR) begin
      ir_r <= ir_sh_r;
    end
  end

  assign bypass_sel = ir_r == tap_pkg::IR_BYPASS;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      byp_r <= tap_pkg::BYP_CAPTURE;
    end else if (rise && bypass_sel && state_r == tap_pkg::CAP_DR) begin
      byp_r <= tap_pkg::BYP_CAPTURE;
    end else if (rise && bypass_sel && state_r == tap_pkg::SH_DR) begin
      byp_r <= sync2_r.tdi;
    end
  end

  // Any non-bypass instruction selects the parallel test data register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tdr_sh_r <= tap_pkg::TDR_RESET;
    end else if (rise && !bypass_sel && state_r == tap_pkg::CAP_DR) begin
      tdr_sh_r <= tdr_r;
    end else if (rise && !bypass_sel && state_r == tap_pkg::SH_DR) begin
      tdr_sh_r <= {sync2_r.tdi, tdr_sh_r[tap_pkg::DR_W-1:1]};
    end
  end

  assign push = fall && !bypass_sel && state_r == tap_pkg::UPD_DR;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tdr_r <= tap_pkg::TDR_RESET;
    end else if (push) begin
      tdr_r <= tdr_sh_r;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tdo_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (fall) begin
      oe_n_r <= !shifting;
      if (state_r == tap_pkg::SH_IR) begin
        tdo_r <= ir_sh_r[0];
      end else if (state_r == tap_pkg::SH_DR) begin
        tdo_r <= bypass_sel ? byp_r : tdr_sh_r[0];
      end
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe_n = oe_n_r;
  assign tap_state = state_r;
  assign ir_out = ir_r;
  assign dr_out = tdr_r;

  // TCK cannot be stalled; a full FIFO drops the update word
  scan_fifo #(.W(tap_pkg::DR_W), .DEPTH(tap_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(dr_push_ready),
    .in_data(tdr_sh_r),
    .out_valid(dr_word_valid),
    .out_ready(dr_word_ready),
    .out_data(dr_word)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ir_capture_a: assert property (rise && state_r == tap_pkg::CAP_IR |=>
    ir_sh_r == tap_pkg::IR_CAPTURE && state_r != tap_pkg::CAP_IR)
    else $error("capture pattern not loaded");
  tdo_enable_a: assert property (fall && shifting |=> !tdo_oe_n)
    else $error("tdo not enabled in shift");
  ir_shift_a: assert property (rise && state_r == tap_pkg::SH_IR |=>
    ir_sh_r[tap_pkg::IR_W-1] == $past(sync2_r.tdi) &&
    ir_sh_r[tap_pkg::IR_W-2:0] == $past(ir_sh_r[tap_pkg::IR_W-1:1]))
    else $error("ir shift wrong");
  tdo_release_a: assert property (fall && (state_r == tap_pkg::EX1_IR ||
    state_r == tap_pkg::EX1_DR) |=> tdo_oe_n)
    else $error("tdo not released in exit1");
  ir_update_a: assert property (fall && state_r == tap_pkg::UPD_IR |=>
    ir_out == $past(ir_sh_r) && bypass_sel == (&$past(ir_sh_r)))
    else $error("instruction not updated");
  bypass_capture_a: assert property (rise && bypass_sel &&
    state_r == tap_pkg::CAP_DR |=> byp_r == tap_pkg::BYP_CAPTURE)
    else $error("bypass bit not cleared");
  bypass_lag_a: assert property (fall && bypass_sel &&
    state_r == tap_pkg::SH_DR |=> tdo == $past(byp_r, 1))
    else $error("bypass path not one stage");
  dr_update_a: assert property (push |=> dr_out == $past(tdr_sh_r))
    else $error("data register not updated");
  tdo_stable_a: assert property (!fall |=>
    $stable(tdo) && $stable(tdo_oe_n))
    else $error("tdo moved off falling edge");
  tlr_return_a: assert property (rise && state_r == tap_pkg::SEL_IR &&
    sync2_r.tms |=> state_r == tap_pkg::TLR)
    else $error("no return to reset");

  ir_scan_c: cover property (fall && state_r == tap_pkg::UPD_IR);
  bypass_shift_c: cover property (fall && bypass_sel &&
    state_r == tap_pkg::SH_DR);
  dr_push_c: cover property (push && dr_push_ready);
  fifo_full_c: cover property (!dr_push_ready);
endmodule
